//--- common/adcq_pkg.sv
`default_nettype none
package adcq_pkg;

  // ----------------------------------------
  // command bytes
  // ----------------------------------------
  localparam logic [7:0] CMD_RESET       = 8'h06;
  localparam logic [7:0] CMD_WRITE_CFG   = 8'h40;
  localparam logic [7:0] CMD_READ_CFG    = 8'h20;
  localparam logic [7:0] CMD_START       = 8'h08;
  localparam logic [7:0] CMD_READ_RESULT = 8'h10;
  localparam logic [7:0] CMD_SLEEP       = 8'h02;

  // ----------------------------------------
  // configuration layout
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] inputSelect;
    logic       gain4;
    logic [1:0] rate;
    logic       continuous;
    logic       extRef;
  } adcq_cfg_type;

  localparam adcq_cfg_type CFG_RESET   = adcq_cfg_type'(8'h00);
  localparam logic [2:0]   SEL_SHORTED = 3'h7;

  // ----------------------------------------
  // result coding
  // ----------------------------------------
  localparam int unsigned  LEVEL_W         = 17;
  localparam logic [15:0]  CODE_RESET      = 16'h0000;
  localparam logic [15:0]  CODE_FULL_SCALE = 16'h7fff;
  localparam logic [17:0]  CODE_LIMIT      = 18'h08000;
  localparam logic [7:0]   TX_IDLE_BYTE    = 8'hff;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned MCLK_MHZ        = 250;
  localparam int unsigned CONV_TIME_90_US = 11300;
  localparam int unsigned CONV_CYC_90     = CONV_TIME_90_US * MCLK_MHZ;
  localparam int unsigned CONV_CYC_R0_DEF = CONV_CYC_90 * 4;
  localparam int unsigned CONV_CYC_R2_DEF = CONV_CYC_90 / 4;
  localparam int unsigned CONV_CYC_R3_DEF = CONV_CYC_90 / 8;

  // ----------------------------------------
  // link events and read sources
  // ----------------------------------------
  typedef struct packed {
    logic       valid;
    logic       first;
    logic [7:0] data;
  } adcq_rx_type;

  typedef enum logic [1:0] {
    SRC_NONE   = 2'b00,
    SRC_CFG    = 2'b01,
    SRC_RESULT = 2'b10
  } adcq_src_type;

endpackage
`default_nettype wire

//--- hdl/adcq_command_seq.sv
// How it works
// - command 06h restores the default state
// - command 40h plus one byte writes config
// - command 20h returns the config byte
// - command 08h starts; continuous mode keeps converting
// - ready output falls when a result lands
// - command 10h returns two result bytes
// - command 02h stops conversions and sleeps
// - select 111 shorts inputs, code reads zero
// - rate 90 sps takes 11.3 ms
// - code equals input times gain over reference
// - input at full scale saturates, never wraps
// - new-result flag set on completion, cleared on read
`timescale 1ns/100ps
`default_nettype none
module adcq_command_seq #(
  parameter int unsigned CONV_CYC_R0 = adcq_pkg::CONV_CYC_R0_DEF,
  parameter int unsigned CONV_CYC_R1 = adcq_pkg::CONV_CYC_90,
  parameter int unsigned CONV_CYC_R2 = adcq_pkg::CONV_CYC_R2_DEF,
  parameter int unsigned CONV_CYC_R3 = adcq_pkg::CONV_CYC_R3_DEF
) (
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  input  wire logic                        sclIn,
  input  wire logic                        sdaIn,
  output logic                             sdaOut,
  output logic                             sdaOe,
  input  wire logic [6:0]                  addrPins,
  input  wire logic [3:0][16:0]            ainLevel,
  output logic                             resultReadyNOut,
  output logic                             resultReadyNOe,
  output adcq_pkg::adcq_cfg_type           cfgOut,
  output logic                             newResult,
  output logic                             converting,
  output logic                             asleep
);
  import adcq_pkg::*;

  logic [6:0]   addrSync1_r;
  logic [6:0]   addrSync2_r;
  adcq_rx_type  rxEvt;
  logic         txTake;
  logic [7:0]   txByte;
  adcq_cfg_type cfg_r;
  logic         expectCfg_r;
  adcq_src_type readSrc_r;
  logic [1:0]   rdIdx_r;
  logic [15:0]  latched_r;
  logic         busy_r;
  logic [31:0]  cnt_r;
  logic [31:0]  convLimit;
  logic         convDone;
  logic         sleep_r;
  logic [15:0]  result_r;
  logic [15:0]  codeNxt;
  logic         newResult_r;
  logic         readyLow_r;
  logic         rearm_r;
  logic         readTake;
  logic         cmdReset;
  logic         cmdWrite;
  logic         cmdReadCfg;
  logic         cmdStart;
  logic         cmdRead;
  logic         cmdSleep;

  // ----------------------------------------
  // address pins and bus engine
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      addrSync1_r <= 7'h00;
      addrSync2_r <= 7'h00;
    end
    else
    begin
      addrSync1_r <= addrPins;
      addrSync2_r <= addrSync1_r;
    end
  end

  adcq_i2c_target u_adcq_i2c_target (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .sclIn   (sclIn),
    .sdaIn   (sdaIn),
    .sdaOut  (sdaOut),
    .sdaOe   (sdaOe),
    .devAddr (addrSync2_r),
    .txByte  (txByte),
    .txTake  (txTake),
    .rxEvt   (rxEvt)
  );

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  // the first byte of every write is a command
  assign cmdReset   = rxEvt.valid && rxEvt.first && (rxEvt.data == CMD_RESET);
  assign cmdWrite   = rxEvt.valid && rxEvt.first && (rxEvt.data == CMD_WRITE_CFG);
  assign cmdReadCfg = rxEvt.valid && rxEvt.first && (rxEvt.data == CMD_READ_CFG);
  assign cmdStart   = rxEvt.valid && rxEvt.first && (rxEvt.data == CMD_START);
  assign cmdRead    = rxEvt.valid && rxEvt.first && (rxEvt.data == CMD_READ_RESULT);
  assign cmdSleep   = rxEvt.valid && rxEvt.first && (rxEvt.data == CMD_SLEEP);
  assign readTake   = txTake && (readSrc_r == SRC_RESULT) && (rdIdx_r == 2'h0);

  always_ff @(posedge mclk)
  begin
    if (sys_rst || cmdReset)
    begin
      cfg_r       <= CFG_RESET;
      expectCfg_r <= 1'b0;
    end
    else if (rxEvt.valid)
    begin
      if (expectCfg_r && !rxEvt.first)
        cfg_r <= adcq_cfg_type'(rxEvt.data);
      expectCfg_r <= cmdWrite;
    end
  end

  // ----------------------------------------
  // read-back path
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      readSrc_r <= SRC_NONE;
      rdIdx_r   <= 2'h0;
      latched_r <= CODE_RESET;
    end
    else if (rxEvt.valid && rxEvt.first)
    begin
      readSrc_r <= cmdReadCfg ? SRC_CFG : (cmdRead ? SRC_RESULT : SRC_NONE);
      rdIdx_r   <= 2'h0;
      if (cmdRead)
        latched_r <= result_r;
    end
    else if (txTake && (rdIdx_r != 2'h3))
      rdIdx_r <= 2'(rdIdx_r + 2'h1);
  end

  always_comb
  begin
    txByte = TX_IDLE_BYTE;
    unique case (readSrc_r)
      SRC_CFG:
        if (rdIdx_r == 2'h0)
          txByte = cfg_r;
      SRC_RESULT:
        if (rdIdx_r == 2'h0)
          txByte = latched_r[15:8];
        else if (rdIdx_r == 2'h1)
          txByte = latched_r[7:0];
      default:
        txByte = TX_IDLE_BYTE;
    endcase
  end

  // ----------------------------------------
  // conversion timing
  // ----------------------------------------
  always_comb
  begin
    unique case (cfg_r.rate)
      2'b00: convLimit = 32'(CONV_CYC_R0);
      2'b01: convLimit = 32'(CONV_CYC_R1);
      2'b10: convLimit = 32'(CONV_CYC_R2);
      2'b11: convLimit = 32'(CONV_CYC_R3);
    endcase
  end

  // a stop, reset or restart in the last cycle discards that result
  assign convDone = busy_r && (cnt_r >= 32'(convLimit - 32'h1)) && !cmdStart && !cmdReset && !cmdSleep;

  always_ff @(posedge mclk)
  begin
    if (sys_rst || cmdReset || cmdSleep)
    begin
      busy_r <= 1'b0;
      cnt_r  <= 32'h0;
    end
    else if (cmdStart)
    begin
      busy_r <= 1'b1;
      cnt_r  <= 32'h0;
    end
    else if (convDone)
    begin
      busy_r <= cfg_r.continuous;
      cnt_r  <= 32'h0;
    end
    else if (busy_r)
      cnt_r <= 32'(cnt_r + 32'h1);
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || cmdReset || cmdStart)
      sleep_r <= 1'b0;
    else if (cmdSleep)
      sleep_r <= 1'b1;
  end

  // ----------------------------------------
  // result coding
  // ----------------------------------------
  // level counts 2^16 per reference volt; code = level * gain / 2
  always_comb
  begin
    logic [16:0] level;
    logic [18:0] scaled;
    level  = (cfg_r.inputSelect == SEL_SHORTED) ? 17'h00000 : ainLevel[cfg_r.inputSelect[1:0]];
    scaled = cfg_r.gain4 ? {level, 2'b00} : {2'b00, level};
    if (scaled[18:1] >= CODE_LIMIT)
      codeNxt = CODE_FULL_SCALE;
    else
      codeNxt = scaled[16:1];
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || cmdReset)
      result_r <= CODE_RESET;
    else if (convDone)
      result_r <= codeNxt;
  end

  // ----------------------------------------
  // new-result flag and ready pin
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      newResult_r <= 1'b0;
    else if (convDone)
      newResult_r <= 1'b1;
    else if (readTake || cmdReset)
      newResult_r <= 1'b0;
  end

  // an unread result is dropped high for one cycle so the next one falls again
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      readyLow_r <= 1'b0;
      rearm_r    <= 1'b0;
    end
    else if (convDone)
    begin
      readyLow_r <= !readyLow_r;
      rearm_r    <= readyLow_r;
    end
    else if (rearm_r || readTake || cmdStart || cmdReset || cmdSleep)
    begin
      // a start, reset or sleep command drops a pending rearm, a read alone does not
      readyLow_r <= rearm_r && !cmdStart && !cmdReset && !cmdSleep;
      rearm_r    <= 1'b0;
    end
  end

  assign resultReadyNOut = 1'b0;
  assign resultReadyNOe  = readyLow_r;
  assign cfgOut          = cfg_r;
  assign newResult       = newResult_r;
  assign converting      = busy_r;
  assign asleep          = sleep_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_reset_cmd;
    @(posedge mclk) disable iff (sys_rst)
    cmdReset |=> (cfg_r == CFG_RESET) && !busy_r && !newResult_r && (result_r == CODE_RESET);
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command left old state");

  property p_write_cfg;
    @(posedge mclk) disable iff (sys_rst)
    (rxEvt.valid && !rxEvt.first && expectCfg_r) |=> (cfg_r == $past(rxEvt.data));
  endproperty
  a_write_cfg: assert property (p_write_cfg) else $error("config byte not stored");

  property p_read_cfg;
    @(posedge mclk) disable iff (sys_rst)
    cmdReadCfg |=> (readSrc_r == SRC_CFG) && (txByte == cfg_r);
  endproperty
  a_read_cfg: assert property (p_read_cfg) else $error("config read-back wrong");

  property p_start;
    @(posedge mclk) disable iff (sys_rst)
    cmdStart |=> busy_r && (cnt_r == 32'h0) && !sleep_r && !readyLow_r;
  endproperty
  a_start: assert property (p_start) else $error("start did not begin a conversion");

  property p_ready_falls;
    @(posedge mclk) disable iff (sys_rst)
    convDone |-> ##[1:2] (readyLow_r || $past(cmdStart || cmdReset || cmdSleep));
  endproperty
  a_ready_falls: assert property (p_ready_falls) else $error("ready pin did not fall");

  property p_read_order;
    @(posedge mclk) disable iff (sys_rst)
    cmdRead |=> (latched_r == $past(result_r)) && (txByte == latched_r[15:8]);
  endproperty
  a_read_order: assert property (p_read_order) else $error("result not sent msb first");

  property p_sleep;
    @(posedge mclk) disable iff (sys_rst)
    cmdSleep |=> (!busy_r && sleep_r && !readyLow_r) [*2];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not stop conversions");

  property p_shorted;
    @(posedge mclk) disable iff (sys_rst)
    (convDone && (cfg_r.inputSelect == SEL_SHORTED)) |=> (result_r == 16'h0000);
  endproperty
  a_shorted: assert property (p_shorted) else $error("shorted input gave nonzero code");

  property p_conv_len;
    @(posedge mclk) disable iff (sys_rst)
    (convDone && $stable(cfg_r.rate)) |-> (cnt_r == 32'(convLimit - 32'h1));
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_saturate;
    @(posedge mclk) disable iff (sys_rst)
    (convDone && (ainLevel[cfg_r.inputSelect[1:0]] >= (cfg_r.gain4 ? 17'h04000 : 17'h10000))
      && (cfg_r.inputSelect != SEL_SHORTED)) |=> (result_r == CODE_FULL_SCALE);
  endproperty
  a_saturate: assert property (p_saturate) else $error("full-scale input wrapped");

  property p_flag_clear;
    @(posedge mclk) disable iff (sys_rst)
    (readTake && !convDone && !rearm_r) |=> !newResult_r ##1 (!readyLow_r || rearm_r || $past(convDone));
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("read did not clear result flag");

  property p_rearm;
    @(posedge mclk) disable iff (sys_rst)
    (convDone && readyLow_r) |=> !readyLow_r ##1 (readyLow_r || $past(cmdStart || cmdReset || cmdSleep));
  endproperty
  a_rearm: assert property (p_rearm) else $error("unread result gave no fresh edge");

endmodule // adcq_command_seq
`default_nettype wire

//--- hdl/adcq_i2c_target.sv
`timescale 1ns/100ps
`default_nettype none
module adcq_i2c_target (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire logic                  sclIn,
  input  wire logic                  sdaIn,
  output logic                       sdaOut,
  output logic                       sdaOe,
  input  wire logic [6:0]            devAddr,
  input  wire logic [7:0]            txByte,
  output logic                       txTake,
  output adcq_pkg::adcq_rx_type      rxEvt
);
  import adcq_pkg::*;

  typedef enum logic [2:0] {
    BUS_IDLE     = 3'b000,
    BUS_ADDR     = 3'b001,
    BUS_ADDR_ACK = 3'b010,
    BUS_WRITE    = 3'b011,
    BUS_WR_ACK   = 3'b100,
    BUS_READ     = 3'b101,
    BUS_RD_ACK   = 3'b110
  } adcq_bus_type;

  adcq_bus_type state_r;
  logic [1:0]   sclSync_r;
  logic [1:0]   sdaSync_r;
  logic         sclPrev_r;
  logic         sdaPrev_r;
  logic [7:0]   shift_r;
  logic [3:0]   bitCnt_r;
  logic         rw_r;
  logic         acked_r;
  logic         first_r;
  logic         sdaLow_r;
  logic         sclRise;
  logic         sclFall;
  logic         startCond;
  logic         stopCond;
  logic         byteIn;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sclSync_r <= 2'h3;
      sdaSync_r <= 2'h3;
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end
    else
    begin
      sclSync_r <= {sclSync_r[0], sclIn};
      sdaSync_r <= {sdaSync_r[0], sdaIn};
      sclPrev_r <= sclSync_r[1];
      sdaPrev_r <= sdaSync_r[1];
    end
  end

  assign sclRise   = sclSync_r[1] & ~sclPrev_r;
  assign sclFall   = ~sclSync_r[1] & sclPrev_r;
  assign startCond = sclSync_r[1] & sclPrev_r & sdaPrev_r & ~sdaSync_r[1];
  assign stopCond  = sclSync_r[1] & sclPrev_r & ~sdaPrev_r & sdaSync_r[1];
  assign byteIn    = sclFall && (bitCnt_r == 4'h8);
  assign txTake    = sclFall && (((state_r == BUS_ADDR_ACK) && rw_r) || ((state_r == BUS_RD_ACK) && acked_r));

  // ----------------------------------------
  // byte engine
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_r  <= BUS_IDLE;
      shift_r  <= 8'h00;
      bitCnt_r <= 4'h0;
      rw_r     <= 1'b0;
      acked_r  <= 1'b0;
      first_r  <= 1'b0;
      sdaLow_r <= 1'b0;
    end
    else if (startCond)
    begin
      state_r  <= BUS_ADDR;
      bitCnt_r <= 4'h0;
      sdaLow_r <= 1'b0;
    end
    else if (stopCond)
    begin
      state_r  <= BUS_IDLE;
      sdaLow_r <= 1'b0;
    end
    else if (txTake)
    begin
      // msb leaves first, data sits on the line before the next rise
      state_r  <= BUS_READ;
      sdaLow_r <= ~txByte[7];
      shift_r  <= {txByte[6:0], 1'b0};
      bitCnt_r <= 4'h0;
    end
    else
    begin
      unique case (state_r)
        BUS_IDLE:
        begin
        end
        BUS_ADDR, BUS_WRITE:
        begin
          if (sclRise)
          begin
            shift_r  <= {shift_r[6:0], sdaSync_r[1]};
            bitCnt_r <= 4'(bitCnt_r + 4'h1);
          end
          else if (byteIn && (state_r == BUS_WRITE))
          begin
            sdaLow_r <= 1'b1;
            state_r  <= BUS_WR_ACK;
          end
          else if (byteIn && (shift_r[7:1] == devAddr))
          begin
            sdaLow_r <= 1'b1;
            rw_r     <= shift_r[0];
            first_r  <= 1'b1;
            state_r  <= BUS_ADDR_ACK;
          end
          else if (byteIn)
          begin
            state_r <= BUS_IDLE;
          end
        end
        BUS_ADDR_ACK, BUS_WR_ACK:
        begin
          if (sclFall)
          begin
            sdaLow_r <= 1'b0;
            bitCnt_r <= 4'h0;
            first_r  <= (state_r == BUS_ADDR_ACK);
            state_r  <= BUS_WRITE;
          end
        end
        BUS_READ:
        begin
          if (sclFall && (bitCnt_r == 4'h7))
          begin
            sdaLow_r <= 1'b0;
            state_r  <= BUS_RD_ACK;
          end
          else if (sclFall)
          begin
            sdaLow_r <= ~shift_r[7];
            shift_r  <= {shift_r[6:0], 1'b0};
            bitCnt_r <= 4'(bitCnt_r + 4'h1);
          end
        end
        BUS_RD_ACK:
        begin
          // a nack ends the read; the host must then stop or restart
          if (sclRise)
            acked_r <= ~sdaSync_r[1];
          else if (sclFall)
            state_r <= BUS_IDLE;
        end
        default:
          state_r <= BUS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // received byte event
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rxEvt <= '0;
    else
    begin
      rxEvt.valid <= byteIn && (state_r == BUS_WRITE) && !startCond && !stopCond;
      rxEvt.first <= first_r;
      rxEvt.data  <= shift_r;
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe  = sdaLow_r;

endmodule // adcq_i2c_target
`default_nettype wire

//--- tb/adcq_command_seq_tb.sv
`timescale 1ns/100ps
`default_nettype none
module adcq_command_seq_tb;
  import adcq_pkg::*;
  localparam int C0       = 2000;
  localparam int C1       = 3000;
  localparam int PWR_WAIT = 250;   // scaled stand-in for the power-up wait
  localparam int LIMIT    = 90000;
  logic             mclk, sys_rst, hostScl, hostOe, dutOe, dutOut, rdyOe, rdyOut, newResult, converting, asleep, ok;
  logic [6:0]       addrPins;
  logic [3:0][16:0] ainLevel;
  adcq_cfg_type     cfgOut;
  logic [15:0]      rv, offs;
  wire              sdaLine;
  int               n_errors = 0;
  int               checked  = 0;
  int               cyc      = 0;
  int               n;
  logic [7:0]       cfgT [4] = '{8'h32, 8'h52, 8'h62, 8'he2};
  logic [15:0]      expT [4] = '{16'h7fff, 16'h7ffe, 16'h091a, 16'h0000};

  assign sdaLine = ~(hostOe | (dutOe & ~dutOut));  // pull-up, either side may pull low

  adcq_command_seq #(.CONV_CYC_R0(C0), .CONV_CYC_R1(C1), .CONV_CYC_R2(1500), .CONV_CYC_R3(1200))
  u_adcq_command_seq (.mclk(mclk), .sys_rst(sys_rst), .sclIn(hostScl), .sdaIn(sdaLine), .sdaOut(dutOut),
    .sdaOe(dutOe), .addrPins(addrPins), .ainLevel(ainLevel), .resultReadyNOut(rdyOut), .resultReadyNOe(rdyOe),
    .cfgOut(cfgOut), .newResult(newResult), .converting(converting), .asleep(asleep));

  adcq_host_model u_adcq_host_model (.mclk(mclk), .sdaIn(sdaLine), .sclOut(hostScl), .sdaOe(hostOe));

  // ----------------------------------------
  // clock, timeout and report
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_errors++;
      $display("ERROR timeout expected end seen hang");
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tx(input logic [7:0] c, input logic [7:0] d, input int nw, input int nr);
    u_adcq_host_model.xfer(addrPins, c, d, nw, nr, rv, ok);
    chk("addrAck", 16'h0001, {15'h0, ok});
  endtask

  // a falling ready pin is a rising pull-down enable; n is the wait in cycles
  task automatic waitRise(input int lim);
    logic prev;
    prev = rdyOe;
    n = 0;
    while (n < lim && !(prev === 1'b0 && rdyOe === 1'b1))
    begin
      prev = rdyOe;
      @(negedge mclk);
      n++;
    end
  endtask

  // ----------------------------------------
  // command sequence
  // ----------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    addrPins = 7'h48;
    ainLevel[0] = 17'h00123;
    ainLevel[1] = 17'h04000;
    ainLevel[2] = 17'h03fff;
    ainLevel[3] = 17'h01235;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    @(negedge mclk);
    chk("resetCfg", 16'h0000, {8'h00, cfgOut});
    chk("resetFlags", 16'h0000, {11'h0, newResult, converting, asleep, rdyOe, dutOe});
    repeat (PWR_WAIT) @(negedge mclk);
    tx(CMD_RESET, 8'h00, 0, 0);
    tx(CMD_WRITE_CFG, 8'h12, 1, 0);
    chk("cfgOut", 16'h0012, {8'h00, cfgOut});
    tx(CMD_READ_CFG, 8'h00, 0, 1);
    chk("cfgRead", 16'h12ff, rv);
    tx(CMD_START, 8'h00, 0, 0);
    chk("started", 16'h0002, {14'h0, converting, asleep});
    waitRise(C0 + 10);
    chk("readyPin", 16'h0006, {13'h0, newResult, rdyOe, rdyOut});
    tx(CMD_READ_RESULT, 8'h00, 0, 2);
    chk("result", 16'h0246, rv);
    chk("cleared", 16'h0000, {14'h0, newResult, rdyOe});
    for (int i = 0; i < 4; i++)
    begin
      tx(CMD_WRITE_CFG, cfgT[i], 1, 0);
      waitRise(C0 + 10);
      tx(CMD_READ_RESULT, 8'h00, 0, 2);
      waitRise(C0 + 10);
      tx(CMD_READ_RESULT, 8'h00, 0, 2);
      chk("code", expT[i], rv);
      if (i == 3)
        offs = rv;
    end
    tx(CMD_WRITE_CFG, 8'h16, 1, 0);
    waitRise(C0 + C1);
    waitRise(C1 + 10);
    chk("period", 16'h0001, {15'h0, (n == C1 || n == C1 + 1)});
    tx(CMD_WRITE_CFG, 8'h1a, 1, 0);
    waitRise(C1 + 10);
    waitRise(1510);
    chk("period2", 16'h0001, {15'h0, (n == 1500 || n == 1501)});
    tx(CMD_WRITE_CFG, 8'h1e, 1, 0);
    waitRise(1510);
    waitRise(1210);
    chk("period3", 16'h0001, {15'h0, (n == 1200 || n == 1201)});
    tx(CMD_RESET, 8'h00, 0, 0);
    chk("cmdReset", 16'h0000, {cfgOut, 6'h0, converting, newResult});
    tx(CMD_START, 8'h00, 0, 0);
    waitRise(C0 + 10);
    tx(CMD_READ_RESULT, 8'h00, 0, 2);
    chk("single", 16'h0091, rv);
    chk("offsetComp", 16'h0091, 16'(rv - offs));
    chk("oneShot", 16'h0000, {15'h0, converting});
    tx(CMD_START, 8'h00, 0, 0);
    tx(CMD_SLEEP, 8'h00, 0, 0);
    chk("sleep", 16'h0004, {13'h0, asleep, converting, rdyOe});
    waitRise(C0 + 500);
    chk("noReady", 16'(C0 + 500), 16'(n));
    u_adcq_host_model.xfer(addrPins ^ 7'h01, CMD_START, 8'h00, 0, 0, rv, ok);
    chk("foreignAddr", 16'h0000, {12'h0, ok, 2'b00, converting});
    end_sim();
  end
endmodule // adcq_command_seq_tb
`default_nettype wire

//--- tb/adcq_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module adcq_host_model (
  input  wire logic mclk,
  input  wire logic sdaIn,
  output logic      sclOut,
  output logic      sdaOe
);
  // ----------------------------------------
  // bus primitives, half bit of 10 mclk
  // ----------------------------------------
  initial
  begin
    sclOut = 1'b1;
    sdaOe  = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // data moves 3 cycles after scl falls, so it never races the clock edge
  task automatic bitx(input logic b, output logic r);
    wt(3);
    sdaOe = !b;
    wt(7);
    sclOut = 1'b1;
    wt(10);
    r = sdaIn;
    sclOut = 1'b0;
  endtask

  task automatic start();
    wt(3);
    sdaOe = 1'b0;
    wt(7);
    sclOut = 1'b1;
    wt(10);
    sdaOe = 1'b1;
    wt(10);
    sclOut = 1'b0;
  endtask

  task automatic stop();
    wt(3);
    sdaOe = 1'b1;
    wt(7);
    sclOut = 1'b1;
    wt(10);
    sdaOe = 1'b0;
    wt(10);
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], r);
    bitx(1'b1, r);
    ak = !r;
  endtask

  // last byte of a read is refused so the target lets go of the line
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'b1, r);
      b[i] = r;
    end
    bitx(last, r);
  endtask

  // ----------------------------------------
  // one command transaction
  // ----------------------------------------
  task automatic xfer(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                      input int nw, input int nr, output logic [15:0] v, output logic ok);
    logic ak;
    v = 16'hffff;
    start();
    wbyte({a, 1'b0}, ok);
    if (ok)
    begin
      wbyte(c, ak);
      if (nw > 0)
        wbyte(d, ak);
      if (nr > 0)
      begin
        start();
        wbyte({a, 1'b1}, ak);
        rbyte(nr == 1, v[15:8]);
        if (nr > 1)
          rbyte(1'b1, v[7:0]);
      end
    end
    stop();
  endtask
endmodule // adcq_host_model
`default_nettype wire
